// ==== ttl_pkg.sv ====
/*
 * Shared constants and carrier types for the thermal trip latch block.
 * Assumes a single 125 MHz system clock and an active-high async reset.
 */
package ttl_pkg;

   // Clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 8000;

   // Trip threshold in degrees Celsius, informational only
   localparam int unsigned TRIP_TEMP_C = 135;

   // Rail shutdown allowance seen from the trip output, in seconds
   localparam int unsigned RAIL_OFF_S = 5;

   // Synchroniser depth for the asynchronous sensor level
   localparam int unsigned SYNC_STAGES = 2;

   // Reset values
   localparam logic TRIP_RST  = 1'h0;
   localparam logic HALT_RST  = 1'h0;
   localparam logic TRIP_N_RST = 1'h1;

   // Latch states
   typedef enum logic [1:0] {
      TTL_RUN      = 2'h0,
      TTL_TRIPPED  = 2'h1,
      TTL_RAILSOFF = 2'h2
   } ttl_state_t;

   // Supply rail status from the power sequencer
   typedef struct packed {
      logic coreSupplyGood;
      logic termination_supply_rail;
   } ttl_rails_t;

   // Outputs toward core and system
   typedef struct packed {
      logic haltExec;
      logic thermal_trip_n;
      logic thermal_trip_oe_n;
   } ttl_out_t;

endpackage

// ==== ttl_sync.sv ====
/*
 * Two-flop level synchroniser for the over-temperature sensor level.
 * Assumes the input may change at any time relative to sys_clk.
 */
`timescale 1ns/1ps
module ttl_sync (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic asyncIn,
   output logic      syncOut
);

   logic stage1_ff;
   logic stage2_ff;
   logic nxt_stage1;
   logic nxt_stage2;

   // Next values of the two stages
   always_comb begin
      nxt_stage1 = asyncIn;
      nxt_stage2 = stage1_ff;
   end

   // Stage registers, first stage read only by the second
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1_ff <= 1'h0;
         stage2_ff <= 1'h0;
      end else begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
      end
   end

   assign syncOut = stage2_ff;

endmodule

// ==== ttl_thermal_trip.sv ====
/*
 * Thermal trip latch: halts execution and drives an open-drain active-low
 * trip output on over-temperature; the pin holds until reset or rail removal, the halt until reset or a cool power return.
 * Assumes the sensor level is asynchronous and the power sequencer reports
 * both rails; reset is the system reset, asynchronous and active high.
 */
`timescale 1ns/1ps

module ttl_thermal_trip (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             overTempAsync,
   input  ttl_pkg::ttl_rails_t   railStatus,
   output logic                  haltExec,
   output logic                  thermal_trip_n,
   output logic                  thermal_trip_oe_n
);

   logic                 overTemp;
   logic                 railsOff;
   ttl_pkg::ttl_state_t  state_ff;
   ttl_pkg::ttl_state_t  nxt_state;
   ttl_pkg::ttl_out_t    out_ff;
   ttl_pkg::ttl_out_t    nxt_out;

   // True only in the state that pulls the trip pin low
   // Shared by the level and the open-drain enable so they cannot drift apart
   function automatic logic trip_driven(input ttl_pkg::ttl_state_t s);
      logic r;
      r = (s == ttl_pkg::TTL_TRIPPED);
      return r;
   endfunction

   // True in every state that keeps the core stopped
   // Rails-off keeps the halt so a partial power return cannot run a hot core
   function automatic logic core_halted(input ttl_pkg::ttl_state_t s);
      logic r;
      r = (s != ttl_pkg::TTL_RUN);
      return r;
   endfunction

   // Power counts as removed only when both rails are down
   // One rail alone still feeds the die, so the trip must keep standing
   function automatic logic rails_gone(input ttl_pkg::ttl_rails_t rs);
      logic g;
      g = !rs.coreSupplyGood && !rs.termination_supply_rail;
      return g;
   endfunction

   // Sensor crossing into the clock domain
   ttl_sync u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .asyncIn (overTempAsync),
      .syncOut (overTemp)
   );

   // Both rails gone counts as core power removed
   assign railsOff = rails_gone(railStatus);

   // Latch state and registered outputs
   always_comb begin
      nxt_state = state_ff;
      nxt_out   = out_ff;
      case (state_ff)
         ttl_pkg::TTL_RUN: begin
            if (overTemp) begin
               nxt_state = ttl_pkg::TTL_TRIPPED;
            end
         end
         ttl_pkg::TTL_TRIPPED: begin
            if (railsOff) begin
               nxt_state = ttl_pkg::TTL_RAILSOFF;
            end
         end
         ttl_pkg::TTL_RAILSOFF: begin
            if (!railsOff) begin
               nxt_state = overTemp ? ttl_pkg::TTL_TRIPPED : ttl_pkg::TTL_RUN;
            end
         end
         default: begin
            nxt_state = ttl_pkg::TTL_TRIPPED;
         end
      endcase
      // Halt held through the whole tripped period
      nxt_out.haltExec          = core_halted(nxt_state);
      nxt_out.thermal_trip_n    = !trip_driven(nxt_state);
      nxt_out.thermal_trip_oe_n = !trip_driven(nxt_state);
   end

   // Reset clears the latch; a still-hot sensor re-trips on the third clock after release, once synchronised
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_ff                  <= ttl_pkg::TTL_RUN;
         out_ff.haltExec           <= ttl_pkg::HALT_RST;
         out_ff.thermal_trip_n     <= ttl_pkg::TRIP_N_RST;
         out_ff.thermal_trip_oe_n  <= ttl_pkg::TRIP_N_RST;
      end else begin
         state_ff <= nxt_state;
         out_ff   <= nxt_out;
      end
   end

   assign haltExec          = out_ff.haltExec;
   assign thermal_trip_n    = out_ff.thermal_trip_n;
   assign thermal_trip_oe_n = out_ff.thermal_trip_oe_n;

   // Assertions
   sequence hotSeen_s;
      !haltExec && overTemp;
   endsequence

   sequence tripOn_s;
      haltExec && !thermal_trip_n;
   endsequence

   trip_on_hot_a : assert property (@(posedge sys_clk) disable iff (reset)
      hotSeen_s |=> tripOn_s)
      else $error("trip not raised after over-temperature");

   trip_held_a : assert property (@(posedge sys_clk) disable iff (reset)
      (!thermal_trip_n && !railsOff) |=> !thermal_trip_n)
      else $error("trip released without reset or rail loss");

   halt_held_a : assert property (@(posedge sys_clk) disable iff (reset)
      haltExec && !(state_ff == ttl_pkg::TTL_RAILSOFF && !railsOff) |=> haltExec)
      else $error("halt released without reset");

   cool_resume_a : assert property (@(posedge sys_clk)
      ($fell(reset) && !overTemp) |-> !haltExec)
      else $error("halt not cleared by reset while cool");

   // Still hot at release: trip returns once the sensor has crossed over
   hot_retrip_a : assert property (@(posedge sys_clk)
      ($fell(reset) && overTempAsync) |-> ##[1:3] (!thermal_trip_n && haltExec))
      else $error("trip not held after reset while hot");

   rails_release_a : assert property (@(posedge sys_clk) disable iff (reset)
      (!thermal_trip_n && railsOff) |=> thermal_trip_n && thermal_trip_oe_n)
      else $error("trip not released after rails off");

   oe_match_a : assert property (@(posedge sys_clk) disable iff (reset)
      thermal_trip_oe_n == thermal_trip_n)
      else $error("trip enable and level disagree");

   sync_delay_a : assert property (@(posedge sys_clk) disable iff (reset)
      $rose(overTempAsync) ##1 overTempAsync [*2] |-> overTemp)
      else $error("sensor not seen two cycles after change");

   // Both rails down while the pin is pulled low
   sequence railsDown_s;
      railsOff && !thermal_trip_n;
   endsequence

   // Pin released but core still stopped
   sequence releasedHalted_s;
      thermal_trip_n && haltExec;
   endsequence

   // The pin never shows a trip while the core runs
   trip_implies_halt_a : assert property (@(posedge sys_clk) disable iff (reset)
      !thermal_trip_n |-> haltExec)
      else $error("trip pin low while core runs");

   // Cooling alone must not clear a latched trip
   sensor_ignored_a : assert property (@(posedge sys_clk) disable iff (reset)
      (!thermal_trip_n && !overTemp && !railsOff) |=> !thermal_trip_n && haltExec)
      else $error("cooling alone cleared the trip");

   // Rail loss releases the pin but keeps the core stopped
   railsoff_halt_a : assert property (@(posedge sys_clk) disable iff (reset)
      railsDown_s |=> releasedHalted_s)
      else $error("core not held stopped after rail loss");

   // One rail still up keeps the trip standing
   partial_rail_a : assert property (@(posedge sys_clk) disable iff (reset)
      (!thermal_trip_n && !railStatus.coreSupplyGood && railStatus.termination_supply_rail)
      |=> !thermal_trip_n)
      else $error("trip released with one rail still up");

   // Power returning to a cool die lets the core run again
   power_back_a : assert property (@(posedge sys_clk) disable iff (reset)
      (state_ff == ttl_pkg::TTL_RAILSOFF && !railsOff && !overTemp)
      |=> !haltExec && thermal_trip_n)
      else $error("core not resumed after cool power return");

   // A cool running core keeps running
   no_trip_cool_a : assert property (@(posedge sys_clk) disable iff (reset)
      (!haltExec && !overTemp) |=> !haltExec)
      else $error("halt raised without over-temperature");

   // Halt only drops on the way out of the rails-off state
   halt_release_a : assert property (@(posedge sys_clk) disable iff (reset)
      $fell(haltExec) |-> $past(state_ff) == ttl_pkg::TTL_RAILSOFF)
      else $error("halt dropped without power return");

endmodule

// ==== ttl_power_seq.sv ====
/* Power sequencer model for the trip output's far side.
   Assumes the trip output is active low, seen on sys_clk. */
`timescale 1ns/1ps
module ttl_power_seq (
   input  wire logic           sys_clk,
   input  wire logic           tripN,
   input  wire logic [7:0]     dropDly,
   input  wire logic           rePower,
   input  wire logic           railHold,
   output ttl_pkg::ttl_rails_t rails
);
   logic [7:0] waitCnt;
   initial begin
      rails = 2'h3;
      waitCnt = 8'h00;
   end
   // Drop both rails after a delay; power returns only on request
   always @(posedge sys_clk) begin
      if (rePower) begin
         rails <= 2'h3;
         waitCnt <= 8'h00;
      end else if (!tripN && !railHold && rails != 2'h0) begin
         waitCnt <= waitCnt + 8'h01;
         // Core rail goes first, termination rail one cycle later
         if (rails == 2'h1) rails <= 2'h0;
         else if (waitCnt >= dropDly) rails <= 2'h1;
      end
   end
endmodule

// ==== ttl_thermal_trip_tb_top.sv ====
/* Bench for the thermal trip latch.
   Assumes the power sequencer model drives the rail flags. */
`timescale 1ns/1ps
module ttl_thermal_trip_tb_top;
   logic                sys_clk;
   logic                reset;
   logic                overTempAsync;
   logic                rePower;
   logic                railHold;
   logic [7:0]          dropDly;
   ttl_pkg::ttl_rails_t railStatus;
   logic                haltExec;
   logic                thermal_trip_n;
   logic                thermal_trip_oe_n;
   logic [2:0]          noteQ[$];
   logic [2:0]          prevOut;
   logic [31:0]         rng;
   int                  errors;
   int                  checks;

   ttl_thermal_trip u_ttl_thermal_trip (.sys_clk(sys_clk), .reset(reset),
      .overTempAsync(overTempAsync), .railStatus(railStatus), .haltExec(haltExec),
      .thermal_trip_n(thermal_trip_n), .thermal_trip_oe_n(thermal_trip_oe_n));
   ttl_power_seq u_ttl_power_seq (.sys_clk(sys_clk), .tripN(thermal_trip_n),
      .dropDly(dropDly), .rePower(rePower), .railHold(railHold), .rails(railStatus));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic cmp_out(input string what, input logic [2:0] exp, input logic [2:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Wait for all notes to be consumed, then a quiet stretch
   task automatic settle();
      int n;
      n = 0;
      while (noteQ.size() != 0 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (noteQ.size() != 0) begin
         errors++;
         close_out();
      end else begin
         repeat (8) @(posedge sys_clk);
      end
   endtask

   task automatic pulse_reset();
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
   endtask

   // Clock generator
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Every output change takes the oldest note; an extra change meets X
   always @(negedge sys_clk) begin
      if ({haltExec, thermal_trip_n, thermal_trip_oe_n} !== prevOut) begin
         prevOut = {haltExec, thermal_trip_n, thermal_trip_oe_n};
         cmp_out("outputs", noteQ.size() ? noteQ.pop_front() : 3'hX, prevOut);
      end
   end

   // Stimulus sequence
   initial begin
      reset = 1'b1;
      overTempAsync = 1'b0;
      rePower = 1'b0;
      dropDly = 8'h00;
      errors = 0;
      checks = 0;
      rng = 32'hB8108740;
      prevOut = 3'h3;
      railHold = 1'b1;
      repeat (3) @(posedge sys_clk);
      // Hot at release, rails held up so the latch must stand alone
      reset <= 1'b0;
      overTempAsync <= 1'b1;
      noteQ.push_back(3'h4);
      settle();
      // Random sensor chatter while latched must change nothing
      for (int k = 0; k < 16; k++) begin
         rng = xs(rng);
         overTempAsync <= rng[0];
         @(posedge sys_clk);
      end
      overTempAsync <= 1'b0;
      settle();
      overTempAsync <= 1'b1;
      noteQ.push_back(3'h3);
      noteQ.push_back(3'h4);
      pulse_reset();
      settle();
      overTempAsync <= 1'b0;
      repeat (4) @(posedge sys_clk);
      noteQ.push_back(3'h3);
      pulse_reset();
      settle();
      // Trip, rails removed promptly then slowly, power returns cool
      railHold <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         dropDly <= (i == 0) ? 8'h00 : rng[7:0];
         overTempAsync <= 1'b1;
         noteQ.push_back(3'h4);
         noteQ.push_back(3'h7);
         settle();
         overTempAsync <= 1'b0;
         repeat (4) @(posedge sys_clk);
         noteQ.push_back(3'h3);
         rePower <= 1'b1;
         @(posedge sys_clk);
         rePower <= 1'b0;
         settle();
      end
      close_out();
   end
endmodule
